/* File: verilog/seep_consts.svh */
// constants for the two-wire serial byte memory slave
// What this block does
// - store 256 bytes of eight bits, all reachable over the serial link
// - array forms 32 pages of 8 bytes; upper address bits select page
// - one 8-bit word address selects any byte for random access
// - sample serial data on clock rise, change driven data after clock fall
// - data line is open drain: pulled low or released, never driven high
// - three strap pins are fixed address inputs compared to address word
// - lock input high when a program cycle would start: page is dropped, no array location changes
// - lock input low: reads and writes work normally over whole array
// - page write of up to 8 bytes programmed in one internal cycle
// - partial page writes change only the bytes actually received
// - self-timed program cycle after stop ends within 5 ms, no clocking
// - glitches of 50 ns or less on clock and data are ignored
// - data fall with clock high is start, data rise is stop
// - address word is 1010, three select bits, then read/write bit
// - device pulls data low in ninth clock after each received word, except an address word refused while busy, offline or unmatched, or data with queue full
// - page write increments low three address bits, wrapping in the page
`ifndef SEEP_CONSTS_SVH
`define SEEP_CONSTS_SVH

`define SEEP_CLK_NS      10
`define SEEP_FILT_NS     50
`define SEEP_FILT_CYC    ((`SEEP_FILT_NS + `SEEP_CLK_NS - 1) / `SEEP_CLK_NS + 1)
`define SEEP_TWR_NS      5000000
`define SEEP_TWR_CYC     (`SEEP_TWR_NS / `SEEP_CLK_NS)
`define SEEP_DEV_CODE    4'hA
`define SEEP_PAGE_BYTES  8
`define SEEP_BYTE_BITS   4'h8
`define SEEP_TOP_BIT     3'h7
`define SEEP_CTRL_OFS    8'h00
`define SEEP_STAT_OFS    8'h04
`define SEEP_CTRL_OFFL   0
`define SEEP_STAT_BUSY   0
`define SEEP_STAT_LOCK   1
`define SEEP_STAT_ADDR   8

`endif

/* File: verilog/seep_pkg.sv */
// types shared by the serial byte memory slave and its buffer
package seep_pkg;
	typedef enum logic [2:0] {
		SEEP_IDLE,
		SEEP_DEV,
		SEEP_WADR,
		SEEP_WDAT,
		SEEP_READ
	} seep_state_t;

	typedef struct packed {
		logic [2:0] idx;
		logic [7:0] data;
	} seep_wbyte_t;
endpackage

/* File: verilog/seep_fifo.sv */
// small first-in first-out buffer with valid/ready on both sides
`timescale 1ns/1ns
module seep_fifo #(
	parameter int unsigned WIDTH = 11,
	parameter int unsigned DEPTH = 8
) (
	input  wire logic             clk_sys,
	input  wire logic             sys_rst,
	input  wire logic             inValid,
	output wire logic             inReady,
	input  wire logic [WIDTH-1:0] inData,
	output wire logic             outValid,
	input  wire logic             outReady,
	output wire logic [WIDTH-1:0] outData
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] store_r [DEPTH];
	logic [AW-1:0]    wrPtr_r;
	logic [AW-1:0]    rdPtr_r;
	logic [AW:0]      count_r;
	wire  logic       doPush;
	wire  logic       doPop;
	wire  logic [AW-1:0] wrPtr_nxt;
	wire  logic [AW-1:0] rdPtr_nxt;

	assign inReady   = (count_r != (AW+1)'(DEPTH));
	assign outValid  = (count_r != '0);
	assign outData   = store_r[rdPtr_r];
	assign doPush    = inValid & inReady;
	assign doPop     = outValid & outReady;
	assign wrPtr_nxt = (wrPtr_r == AW'(DEPTH - 1)) ? '0 : wrPtr_r + 1'b1;
	assign rdPtr_nxt = (rdPtr_r == AW'(DEPTH - 1)) ? '0 : rdPtr_r + 1'b1;

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
		end else begin
			if (doPush)
				wrPtr_r <= wrPtr_nxt;
			if (doPop)
				rdPtr_r <= rdPtr_nxt;
			if (doPush != doPop)
				count_r <= doPush ? count_r + 1'b1 : count_r - 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (doPush)
			store_r[wrPtr_r] <= inData;
	end
endmodule // seep_fifo

/* File: verilog/seep_slave.sv */
// two-wire serial byte memory slave with an apb status and control port
`timescale 1ns/1ns
`include "seep_consts.svh"
module seep_slave #(
	parameter int unsigned TWR_CYCLES = `SEEP_TWR_CYC,
	parameter int unsigned FIFO_DEPTH = `SEEP_PAGE_BYTES
) (
	input  wire logic                 clk_sys,
	input  wire logic                 sys_rst,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	output wire logic [31:0]          prdata,
	output wire logic                 pready,
	output wire logic                 pslverr,
	input  wire logic                 sclIn,
	input  wire logic                 sdaIn,
	output wire logic                 sdaOut,
	output wire logic                 sdaOe,
	input  wire logic [2:0]           strapSelectPins,
	input  wire logic                 arrayLockIn
);
	import seep_pkg::*;

	localparam int unsigned FILT_CYC = `SEEP_FILT_CYC;
	localparam int unsigned PAGE     = `SEEP_PAGE_BYTES;

	// pin synchronisers: {lock, straps, sda, scl}
	logic [5:0]  pinsMeta_r;
	logic [5:0]  pinsSync_r;
	logic [1:0]  filt_r;
	logic [2:0]  filtCnt_r [2];
	logic        sclPrev_r;
	logic        sdaPrev_r;

	// serial engine
	seep_state_t state_r;
	seep_state_t state_nxt;
	seep_state_t afterAck_r;
	seep_state_t afterAck_nxt;
	logic [3:0]  bitCnt_r;
	logic [3:0]  bitCnt_nxt;
	logic        ackPhase_r;
	logic        ackPhase_nxt;
	logic [7:0]  shift_r;
	logic [7:0]  shift_nxt;
	logic        sdaOe_r;
	logic        sdaOe_nxt;
	logic [7:0]  addrPtr_r;
	logic [7:0]  addrPtr_nxt;
	logic [7:0]  tx_r;
	logic [7:0]  tx_nxt;
	logic        masterAck_r;
	logic        masterAck_nxt;
	logic        pushValid;
	logic        clearPage;
	logic        stopSeen;

	// array, page buffer and program timer
	logic [7:0]  mem_r [256];
	logic [7:0]  rdData_r;
	logic [7:0]  pageBuf_r [PAGE];
	logic [PAGE-1:0] pageMask_r;
	logic [4:0]  pageNum_r;
	logic        progPend_r;
	logic        busy_r;
	logic [31:0] twrCnt_r;
	logic        offline_r;
	logic [31:0] prdata_r;

	wire logic        sclF;
	wire logic        sdaF;
	wire logic [2:0]  strapSync;
	wire logic        lockSync;
	wire logic        sclRise;
	wire logic        sclFall;
	wire logic        startEv;
	wire logic        stopEv;
	wire logic        devMatch;
	wire logic [2:0]  txIdx;
	wire logic        fifoInReady;
	wire logic        fifoOutValid;
	wire logic        fifoOutReady;
	wire seep_wbyte_t fifoIn;
	wire seep_wbyte_t fifoOut;
	wire logic        progStart;
	wire logic        progDrop;
	wire logic        commit;
	wire logic        apbSetup;
	wire logic        apbWrite;
	wire logic        hitCtrl;
	wire logic        hitStat;
	wire logic [31:0] statWord;

	assign sclF      = filt_r[0];
	assign sdaF      = filt_r[1];
	assign strapSync = pinsSync_r[4:2];
	assign lockSync  = pinsSync_r[5];

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			pinsMeta_r <= 6'h23;
			pinsSync_r <= 6'h23;
		end else begin
			pinsMeta_r <= {arrayLockIn, strapSelectPins, sdaIn, sclIn};
			pinsSync_r <= pinsMeta_r;
		end
	end

	// a level change is accepted only after it has held longer than the glitch limit
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gFilt
			always_ff @(posedge clk_sys or posedge sys_rst) begin
				if (sys_rst) begin
					filt_r[g]    <= 1'b1;
					filtCnt_r[g] <= '0;
				end else if (pinsSync_r[g] == filt_r[g]) begin
					filtCnt_r[g] <= '0;
				end else if (filtCnt_r[g] == 3'(FILT_CYC - 1)) begin
					filt_r[g]    <= pinsSync_r[g];
					filtCnt_r[g] <= '0;
				end else begin
					filtCnt_r[g] <= filtCnt_r[g] + 1'b1;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			sclPrev_r <= 1'b1;
			sdaPrev_r <= 1'b1;
		end else begin
			sclPrev_r <= sclF;
			sdaPrev_r <= sdaF;
		end
	end

	assign sclRise  = sclF & ~sclPrev_r;
	assign sclFall  = ~sclF & sclPrev_r;
	assign startEv  = sclF & sclPrev_r & sdaPrev_r & ~sdaF;
	assign stopEv   = sclF & sclPrev_r & ~sdaPrev_r & sdaF;
	assign devMatch = (shift_r[7:4] == `SEEP_DEV_CODE)
	                & (shift_r[3:1] == strapSync)
	                & ~busy_r & ~progPend_r & ~offline_r;
	assign txIdx    = `SEEP_TOP_BIT - bitCnt_r[2:0];
	assign fifoIn   = '{idx: addrPtr_r[2:0], data: shift_r};

	always_comb begin
		state_nxt     = state_r;
		afterAck_nxt  = afterAck_r;
		bitCnt_nxt    = bitCnt_r;
		ackPhase_nxt  = ackPhase_r;
		shift_nxt     = shift_r;
		sdaOe_nxt     = sdaOe_r;
		addrPtr_nxt   = addrPtr_r;
		tx_nxt        = tx_r;
		masterAck_nxt = masterAck_r;
		pushValid     = 1'b0;
		clearPage     = 1'b0;
		stopSeen      = 1'b0;
		if (startEv) begin
			state_nxt    = SEEP_DEV;
			bitCnt_nxt   = '0;
			ackPhase_nxt = 1'b0;
			sdaOe_nxt    = 1'b0;
		end else if (stopEv) begin
			state_nxt    = SEEP_IDLE;
			ackPhase_nxt = 1'b0;
			sdaOe_nxt    = 1'b0;
			stopSeen     = 1'b1;
		end else if (state_r != SEEP_IDLE && sclRise) begin
			if (!ackPhase_r) begin
				shift_nxt  = {shift_r[6:0], sdaF};
				bitCnt_nxt = bitCnt_r + 1'b1;
			end else if (state_r == SEEP_READ) begin
				masterAck_nxt = ~sdaF;
			end
		end else if (state_r != SEEP_IDLE && sclFall) begin
			if (ackPhase_r) begin
				// end of the ninth clock: release (or drive the first read bit) and enter the next word
				ackPhase_nxt = 1'b0;
				bitCnt_nxt   = '0;
				sdaOe_nxt    = 1'b0;
				state_nxt    = afterAck_r;
				if (state_r == SEEP_READ && !masterAck_r) begin
					state_nxt = SEEP_IDLE;
				end else if (afterAck_r == SEEP_READ) begin
					tx_nxt      = rdData_r;
					sdaOe_nxt   = ~rdData_r[`SEEP_TOP_BIT];
					addrPtr_nxt = addrPtr_r + 1'b1;
				end
			end else if (bitCnt_r == `SEEP_BYTE_BITS) begin
				ackPhase_nxt = 1'b1;
				unique case (state_r)
					SEEP_DEV: begin
						if (devMatch) begin
							sdaOe_nxt    = 1'b1;
							afterAck_nxt = shift_r[0] ? SEEP_READ : SEEP_WADR;
						end else begin
							state_nxt    = SEEP_IDLE;
							ackPhase_nxt = 1'b0;
						end
					end
					SEEP_WADR: begin
						sdaOe_nxt    = 1'b1;
						addrPtr_nxt  = shift_r;
						clearPage    = 1'b1;
						afterAck_nxt = SEEP_WDAT;
					end
					SEEP_WDAT: begin
						if (fifoInReady) begin
							sdaOe_nxt    = 1'b1;
							pushValid    = 1'b1;
							addrPtr_nxt  = {addrPtr_r[7:3], addrPtr_r[2:0] + 3'h1};
							afterAck_nxt = SEEP_WDAT;
						end else begin
							state_nxt    = SEEP_IDLE;
							ackPhase_nxt = 1'b0;
						end
					end
					SEEP_READ: begin
						sdaOe_nxt    = 1'b0;
						afterAck_nxt = SEEP_READ;
					end
					SEEP_IDLE: begin
						ackPhase_nxt = 1'b0;
					end
				endcase
			end else if (state_r == SEEP_READ) begin
				sdaOe_nxt = ~tx_r[txIdx];
			end
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			state_r     <= SEEP_IDLE;
			afterAck_r  <= SEEP_IDLE;
			bitCnt_r    <= '0;
			ackPhase_r  <= 1'b0;
			shift_r     <= '0;
			sdaOe_r     <= 1'b0;
			addrPtr_r   <= '0;
			tx_r        <= '0;
			masterAck_r <= 1'b0;
		end else begin
			state_r     <= state_nxt;
			afterAck_r  <= afterAck_nxt;
			bitCnt_r    <= bitCnt_nxt;
			ackPhase_r  <= ackPhase_nxt;
			shift_r     <= shift_nxt;
			sdaOe_r     <= sdaOe_nxt;
			addrPtr_r   <= addrPtr_nxt;
			tx_r        <= tx_nxt;
			masterAck_r <= masterAck_nxt;
		end
	end

	// the line is only ever pulled low or released
	assign sdaOut = 1'b0;
	assign sdaOe  = sdaOe_r;

	// received bytes queue here; a full queue withholds the acknowledge
	assign fifoOutReady = ~busy_r;

	seep_fifo #(
		.WIDTH ($bits(seep_wbyte_t)),
		.DEPTH (FIFO_DEPTH)
	) uFifo (
		.clk_sys  (clk_sys),
		.sys_rst  (sys_rst),
		.inValid  (pushValid),
		.inReady  (fifoInReady),
		.inData   (fifoIn),
		.outValid (fifoOutValid),
		.outReady (fifoOutReady),
		.outData  (fifoOut)
	);

	// page buffer: a later byte at the same slot overwrites the earlier one
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			pageMask_r <= '0;
			pageNum_r  <= '0;
		end else if (clearPage) begin
			pageMask_r <= '0;
			pageNum_r  <= shift_r[7:3];
		end else if (commit || progDrop) begin
			pageMask_r <= '0;
		end else if (fifoOutValid && fifoOutReady) begin
			pageMask_r[fifoOut.idx] <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (fifoOutValid && fifoOutReady)
			pageBuf_r[fifoOut.idx] <= fifoOut.data;
	end

	// program starts once the stop is seen and the queue has drained
	assign progStart = progPend_r & ~fifoOutValid & (pageMask_r != '0) & ~lockSync;
	assign progDrop  = progPend_r & ~fifoOutValid & lockSync;
	assign commit    = busy_r & (twrCnt_r == '0);

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			progPend_r <= 1'b0;
			busy_r     <= 1'b0;
			twrCnt_r   <= '0;
		end else begin
			if (stopSeen)
				progPend_r <= 1'b1;
			else if (!fifoOutValid)
				progPend_r <= 1'b0;
			if (progStart) begin
				busy_r   <= 1'b1;
				twrCnt_r <= 32'(TWR_CYCLES - 1);
			end else if (commit) begin
				busy_r <= 1'b0;
			end else if (busy_r) begin
				twrCnt_r <= twrCnt_r - 1'b1;
			end
		end
	end

	// one commit writes every received byte of the page at once;
	// a single process owns the whole array so no two processes write it
	always_ff @(posedge clk_sys) begin
		for (int i = 0; i < PAGE; i++) begin
			if (commit && pageMask_r[i])
				mem_r[{pageNum_r, 3'(i)}] <= pageBuf_r[i];
		end
	end

	always_ff @(posedge clk_sys) begin
		rdData_r <= mem_r[addrPtr_r];
	end

	// apb slave: answers in the access cycle, unmapped addresses flag an error
	assign apbSetup = psel & ~penable;
	assign apbWrite = psel & penable & pwrite;
	assign hitCtrl  = (paddr == `SEEP_CTRL_OFS);
	assign hitStat  = (paddr == `SEEP_STAT_OFS);
	assign pready   = psel & penable;
	assign pslverr  = pready & ~hitCtrl & ~hitStat;
	assign prdata   = prdata_r;
	assign statWord = {16'h0000, addrPtr_r, 6'h00, lockSync, busy_r};

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			offline_r <= 1'b0;
			prdata_r  <= '0;
		end else begin
			if (apbWrite && hitCtrl)
				offline_r <= pwdata[`SEEP_CTRL_OFFL];
			if (apbSetup)
				prdata_r <= hitCtrl ? {31'h00000000, offline_r} :
				            hitStat ? statWord : 32'h00000000;
		end
	end
endmodule // seep_slave

/* File: verif/seep_slave_asserts.sv */
// port checker for the serial byte memory slave
`timescale 1ns/1ns
module seep_slave_asserts #(
	parameter int unsigned TWR_CYCLES = 500000
) (
	input wire logic        clk_sys,
	input wire logic        sys_rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        sclIn,
	input wire logic        sdaIn,
	input wire logic        sdaOut,
	input wire logic        sdaOe,
	input wire logic [2:0]  strapSelectPins,
	input wire logic        arrayLockIn
);
	logic        sclQ_r;
	logic        sdaQ_r;
	logic        ctrl_r;
	logic [31:0] since_r;
	wire         stopSeen = sclIn && sclQ_r && sdaIn && !sdaQ_r;
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			sclQ_r <= 1'b1;
			sdaQ_r <= 1'b1;
			ctrl_r <= 1'b0;
			since_r <= 32'h0;
		end else begin
			sclQ_r <= sclIn;
			sdaQ_r <= sdaIn;
			if (psel && penable && pwrite && paddr == 8'h00)
				ctrl_r <= pwdata[0];
			since_r <= stopSeen ? 32'h0 : since_r + {31'h0, ~&since_r};
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	sequence apbAcc;
		psel && penable;
	endsequence
	sequence rdOf(a);
		apbAcc ##0 (!pwrite && paddr == a);
	endsequence
	a_drain_only: assert property (sdaOut == 1'b0) else $error("data pin driven high");
	a_ready_now: assert property (pready == (psel && penable)) else $error("pready wrong");
	a_bad_addr: assert property (apbAcc |-> pslverr == !(paddr == 8'h00 || paddr == 8'h04))
		else $error("pslverr wrong");
	a_bad_zero: assert property (apbAcc ##0 (pslverr && !pwrite) |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	a_rsvd_zero: assert property (rdOf(8'h04) |-> prdata[31:16] == 16'h0 && prdata[7:2] == 6'h0)
		else $error("status reserved bits set");
	a_ctrl_back: assert property (rdOf(8'h00) |-> prdata == {31'h0, ctrl_r})
		else $error("control readback wrong");
	a_oe_scl_low: assert property ($changed(sdaOe) |-> !sclIn) else $error("data moved in clock high");
	a_rst_quiet: assert property ($fell(sys_rst) |-> !sdaOe) else $error("data pulled after reset");
	a_twr_bound: assert property (
		rdOf(8'h04) ##0 since_r > TWR_CYCLES + 32 |-> !prdata[0])
		else $error("program cycle too long");
endmodule // seep_slave_asserts
bind seep_slave seep_slave_asserts #(.TWR_CYCLES(TWR_CYCLES)) u_seep_slave_asserts (
	.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
	.strapSelectPins(strapSelectPins), .arrayLockIn(arrayLockIn));

/* File: verif/seep_ctrl_model.sv */
// two-wire bus controller model driving clock and open-drain data
`timescale 1ns/1ns
module seep_ctrl_model (
	input  wire logic clk_sys,
	input  wire logic sdaWire,
	output logic      sclOut,
	output logic      sdaPull
);
	// 50-clock half bit: bus clock at 1 MHz, room for sync and filter delay
	localparam int H = 50;
	initial begin
		sclOut = 1'b1;
		sdaPull = 1'b0;
	end
	task tk(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	// data moves only while the clock is low
	task bitx(input logic b, output logic s);
		sdaPull <= ~b;
		tk(H - 4);
		sclOut <= 1'b1;
		tk(H / 2);
		s = sdaWire;
		tk(H / 2);
		sclOut <= 1'b0;
		tk(4);
	endtask
	task begFrame;
		sdaPull <= 1'b0;
		tk(H);
		sclOut <= 1'b1;
		tk(H);
		sdaPull <= 1'b1;
		tk(H);
		sclOut <= 1'b0;
		tk(4);
	endtask
	task endFrame;
		sdaPull <= 1'b1;
		tk(H - 4);
		sclOut <= 1'b1;
		tk(H);
		sdaPull <= 1'b0;
		tk(H);
	endtask
	// a clock pulse shorter than the glitch limit must not count as an edge
	task spike;
		sclOut <= 1'b1;
		tk(4);
		sclOut <= 1'b0;
		tk(H);
	endtask
	task sendByte(input logic [7:0] v, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bitx(v[i], s);
		bitx(1'b1, s);
		ack = ~s;
	endtask
	task recvByte(input logic more, output logic [7:0] v);
		logic s;
		for (int i = 7; i >= 0; i--) bitx(1'b1, v[i]);
		bitx(~more, s);
	endtask
endmodule // seep_ctrl_model

/* File: verif/tb_seep_slave.sv */
// self-checking bench for the serial byte memory slave
`timescale 1ns/1ns
module tb_seep_slave;
	logic        clk_sys;
	logic        sys_rst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	wire  [31:0] prdata;
	wire         pready;
	wire         pslverr;
	wire         sclIn;
	wire         sdaOe;
	wire         sdaPull;
	wire         sdaW = ~sdaOe & ~sdaPull;
	logic [2:0]  straps;
	logic [2:0]  selBits;
	logic        lock;
	logic [7:0]  expMem [256];
	logic [31:0] q;
	logic        e;
	int          errors;
	int          checks_done;
	seep_slave #(.TWR_CYCLES(2000)) u_seep_slave (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .sclIn(sclIn), .sdaIn(sdaW),
		.sdaOut(), .sdaOe(sdaOe), .strapSelectPins(straps), .arrayLockIn(lock));
	seep_ctrl_model u_seep_ctrl_model (.clk_sys(clk_sys), .sdaWire(sdaW), .sclOut(sclIn),
		.sdaPull(sdaPull));
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task conclude;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] x);
		checks_done++;
		if (s !== x) begin
			errors++;
			$display("unexpected at %0t seen %h expected %h", $time, s, x);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) begin
			errors++;
			conclude();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task idle;
		int k;
		k = 0;
		do begin
			apb(1'b0, 8'h04, 32'h0);
			k++;
		end while (q[0] !== 1'b0 && k < 1000);
		if (k >= 1000) begin
			errors++;
			conclude();
		end
	endtask
	task devSel(input logic rw, input logic want);
		logic a;
		u_seep_ctrl_model.sendByte({4'hA, selBits, rw}, a);
		chk(a, want);
	endtask
	task head(input logic [7:0] adr);
		logic a;
		u_seep_ctrl_model.begFrame();
		devSel(1'b0, 1'b1);
		u_seep_ctrl_model.sendByte(adr, a);
		chk(a, 1'b1);
	endtask
	task wrPage(input logic [7:0] adr, input int n, input logic [7:0] d0);
		logic a;
		head(adr);
		for (int i = 0; i < n; i++) begin
			u_seep_ctrl_model.sendByte(8'(d0 + i), a);
			chk(a, 1'b1);
			if (!lock)
				expMem[{adr[7:3], 3'(adr[2:0] + i)}] = 8'(d0 + i);
		end
		u_seep_ctrl_model.endFrame();
	endtask
	task rdSeq(input logic [7:0] adr, input int n);
		logic [7:0] v;
		head(adr);
		u_seep_ctrl_model.begFrame();
		devSel(1'b1, 1'b1);
		for (int i = 0; i < n; i++) begin
			u_seep_ctrl_model.recvByte(i < n - 1, v);
			chk(v, expMem[8'(adr + i)]);
		end
		u_seep_ctrl_model.endFrame();
	endtask
	initial begin
		sys_rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		straps = 3'h5;
		selBits = 3'h5;
		lock = 1'b0;
		errors = 0;
		checks_done = 0;
		repeat (16) @(posedge clk_sys);
		sys_rst <= 1'b0;
		repeat (20) @(posedge clk_sys);
		apb(1'b0, 8'h00, 32'h0);
		chk(q, 32'h0);
		apb(1'b0, 8'h04, 32'h0);
		chk(q, 32'h0);
		apb(1'b0, 8'h08, 32'h0);
		chk({q[30:0], e}, 32'h1);
		$display("test registers done");
		wrPage(8'h28, 8, 8'h40);
		apb(1'b0, 8'h04, 32'h0);
		chk(q[0], 1'b1);
		// address word refused while programming
		u_seep_ctrl_model.begFrame();
		devSel(1'b0, 1'b0);
		u_seep_ctrl_model.endFrame();
		idle();
		wrPage(8'h2E, 3, 8'hC0);
		idle();
		chk(q[15:8], 8'h29);
		rdSeq(8'h28, 8);
		$display("test page write done");
		lock <= 1'b1;
		wrPage(8'h2A, 1, 8'h55);
		apb(1'b0, 8'h04, 32'h0);
		chk(q[1:0], 2'h2);
		lock <= 1'b0;
		rdSeq(8'h2A, 1);
		$display("test lock done");
		selBits = 3'h0;
		u_seep_ctrl_model.begFrame();
		devSel(1'b0, 1'b0);
		u_seep_ctrl_model.endFrame();
		straps <= 3'h0;
		wrPage(8'hFF, 1, 8'h77);
		idle();
		wrPage(8'h00, 1, 8'h88);
		idle();
		rdSeq(8'hFF, 2);
		u_seep_ctrl_model.begFrame();
		u_seep_ctrl_model.spike();
		devSel(1'b0, 1'b1);
		u_seep_ctrl_model.endFrame();
		$display("test select done");
		apb(1'b1, 8'h00, 32'h1);
		apb(1'b0, 8'h00, 32'h0);
		chk(q, 32'h1);
		u_seep_ctrl_model.begFrame();
		devSel(1'b1, 1'b0);
		u_seep_ctrl_model.endFrame();
		apb(1'b1, 8'h00, 32'h0);
		$display("test offline done");
		conclude();
	end
endmodule // tb_seep_slave
